// [breaker_stats_event_recorder.sv]
`timescale 1ns/100ps
module breaker_stats_event_recorder
  import breaker_stats_pkg::*;
#(
  parameter int DEPTH = LOG_DEPTH
) (
  // Clock and reset.
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  // Breaker, trip relay and statistics sources.
  input  wire logic                          breaker_open,
  input  wire logic                          trip_relay_req,
  input  wire logic [3:0]                    trip_cause_id,
  input  wire logic                          trip_cause_valid,
  input  wire logic                          stats_inhibit,
  input  wire logic [2:0]                    arc_valid,
  input  wire logic [2:0][15:0]              arc_incr,
  // Protection elements.
  input  wire logic [NUM_ELEM-1:0]           elem_pickup,
  input  wire logic [NUM_ELEM-1:0]           elem_operate,
  input  wire elem_func_t [NUM_ELEM-1:0]     elem_func,
  input  wire logic [NUM_ELEM-1:0][2:0]      elem_phases,
  // Logic inputs.
  input  wire logic [NUM_INPUTS-1:0]         contact_in,
  input  wire logic [NUM_INPUTS-1:0]         virtual_in,
  // Time, measurements and settings.
  input  wire stamp_t                        now,
  input  wire meas_t                         meas,
  input  wire logic                          vt_wiring_style,
  input  wire logic [8:0]                    type_filter,
  // Commands.
  input  wire logic                          reset_trip_cmd,
  input  wire logic                          reset_arc_cmd,
  input  wire logic                          clear_log_cmd,
  // Display side.
  input  wire logic [$clog2(DEPTH)-1:0]      rd_age,
  input  wire logic                          rd_req,
  output logic                               rd_valid,
  output event_t                             rd_event,
  output logic [$clog2(DEPTH):0]             log_count,
  output logic [31:0]                        breaker_trips,
  output logic [NUM_CAUSE_CNT-1:0][15:0]     cause_trips,
  output logic [2:0][15:0]                   arc_total,
  output logic [31:0]                        trip_reset_date,
  output logic [31:0]                        arc_reset_date
);

  localparam int AW = $clog2(DEPTH);

  // The pointer arithmetic wraps by width alone, so only powers of two are served.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("DEPTH must be a power of two of at least 2");
  end

  // The array stands for the non-volatile store; it is not reset, but srst clears wr_ptr
  // and log_count, so after a reset its old contents no longer read back as valid.
  event_t log_mem [DEPTH];
  logic [AW-1:0]        wr_ptr;
  logic [15:0]          seq;
  logic                 prev_open;
  logic                 prev_trip;
  logic [NUM_ELEM-1:0]  prev_pickup;
  logic [NUM_ELEM-1:0]  prev_operate;
  logic [NUM_ELEM-1:0]  pickup_logged;
  logic [NUM_INPUTS-1:0] prev_contact;
  logic [NUM_INPUTS-1:0] prev_virtual;

  // One event is stored per cycle; pending sources are picked by priority and
  // their edges stay pending until served, so none is lost when several coincide.
  logic [NUM_ELEM-1:0]   pend_pu;
  logic [NUM_ELEM-1:0]   pend_op;
  logic [NUM_ELEM-1:0]   pend_do;
  logic [NUM_INPUTS-1:0] pend_ci;
  logic [NUM_INPUTS-1:0] pend_vi;
  logic [4:0]            pend_gen;

  logic     ev_fire;
  event_t   next_ev;
  logic [NUM_ELEM-1:0]   clr_pu, clr_op, clr_do;
  logic [NUM_INPUTS-1:0] clr_ci, clr_vi;
  logic [4:0]            clr_gen;
  snap_t    snap_now;

  logic trip_edge;
  assign trip_edge = trip_relay_req && !prev_trip;

  always_comb begin
    snap_now.cur       = {meas.sgnd, meas.gnd, meas.ia};
    snap_now.v         = vt_wiring_style ? meas.v_ll : meas.v_ln;
    snap_now.sys_freq  = meas.sys_freq;
    snap_now.sync_v    = meas.sync_v;
    snap_now.sync_freq = meas.sync_freq;
    snap_now.analog    = meas.analog;
  end

  // Edge memories reset to the idle level of their sources, so no false edge follows reset.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prev_open <= 1'b0;
      prev_trip <= 1'b0;
    end else begin
      prev_open <= breaker_open;
      prev_trip <= trip_relay_req;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prev_pickup  <= '0;
      prev_operate <= '0;
    end else begin
      prev_pickup  <= elem_pickup;
      prev_operate <= elem_operate;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prev_contact <= '0;
      prev_virtual <= '0;
    end else begin
      prev_contact <= contact_in;
      prev_virtual <= virtual_in;
    end
  end

  // Pending event flags: a new edge wins over the serve of the same bit.
  always_ff @(posedge core_clk) begin
    if (srst || clear_log_cmd)
      pend_pu <= '0;
    else
      pend_pu <= (pend_pu & ~clr_pu) | (elem_pickup & ~prev_pickup);
  end

  always_ff @(posedge core_clk) begin
    if (srst || clear_log_cmd)
      pend_op <= '0;
    else
      pend_op <= (pend_op & ~clr_op) | (elem_operate ^ prev_operate);
  end

  always_ff @(posedge core_clk) begin
    if (srst || clear_log_cmd)
      pend_do <= '0;
    else
      pend_do <= (pend_do & ~clr_do)
               | (~elem_pickup & prev_pickup & pickup_logged);
  end

  always_ff @(posedge core_clk) begin
    if (srst || clear_log_cmd)
      pend_ci <= '0;
    else
      pend_ci <= (pend_ci & ~clr_ci) | (contact_in ^ prev_contact);
  end

  always_ff @(posedge core_clk) begin
    if (srst || clear_log_cmd)
      pend_vi <= '0;
    else
      pend_vi <= (pend_vi & ~clr_vi) | (virtual_in ^ prev_virtual);
  end

  // A log clear leaves exactly one pending event behind: its own general entry.
  always_ff @(posedge core_clk) begin
    if (srst)
      pend_gen <= 5'h00;
    else if (clear_log_cmd)
      pend_gen <= 5'h10;
    else
      pend_gen <= (pend_gen & ~clr_gen)
                | {1'b0, reset_arc_cmd, reset_trip_cmd,
                   !breaker_open && prev_open, breaker_open && !prev_open};
  end

  always_ff @(posedge core_clk) begin
    if (srst || clear_log_cmd)
      pickup_logged <= '0;
    else
      pickup_logged <= (pickup_logged | (clr_pu & {NUM_ELEM{ev_fire}})) & ~clr_do;
  end

  // Selects one pending event, fills its header and snapshot.
  always_comb begin
    ev_fire  = 1'b0;
    next_ev  = '0;
    clr_pu   = '0;
    clr_op   = '0;
    clr_do   = '0;
    clr_ci   = '0;
    clr_vi   = '0;
    clr_gen  = '0;
    next_ev.seq   = seq + 16'h0001;
    next_ev.stamp = now;
    next_ev.delta = vt_wiring_style;
    next_ev.snap  = snap_now;
    for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
      if (pend_vi[i]) begin
        clr_vi = '0;
        clr_vi[i] = 1'b1;
        next_ev.etype = EV_VIRTUAL;
        next_ev.cause = 8'(i);
        next_ev.on_state = virtual_in[i];
      end
    end
    for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
      if (pend_ci[i] && clr_vi == '0) begin
        clr_ci = '0;
        clr_ci[i] = 1'b1;
        next_ev.etype = EV_CONTACT;
        next_ev.cause = 8'(i);
        next_ev.on_state = contact_in[i];
      end
    end
    for (int i = NUM_ELEM - 1; i >= 0; i--) begin
      if (clr_vi == '0 && clr_ci == '0) begin
        if (pend_do[i]) begin
          clr_do = '0;
          clr_pu = '0;
          clr_op = '0;
          clr_do[i] = 1'b1;
          next_ev.etype = EV_DROPOUT;
        end else if (pend_pu[i]) begin
          clr_do = '0;
          clr_pu = '0;
          clr_op = '0;
          clr_pu[i] = 1'b1;
          next_ev.etype = EV_PICKUP;
        end else if (pend_op[i]) begin
          clr_do = '0;
          clr_pu = '0;
          clr_op = '0;
          clr_op[i] = 1'b1;
          case (elem_func[i])
            FN_TRIP, FN_TRIP_RECLOSE: next_ev.etype = EV_TRIP;
            FN_ALARM:                 next_ev.etype = EV_ALARM;
            FN_LATCHED:               next_ev.etype = EV_LATCHED;
            FN_CONTROL:               next_ev.etype = EV_CONTROL;
            default:                  next_ev.etype = EV_GENERAL;
          endcase
        end
        if (clr_do[i] || clr_pu[i] || clr_op[i]) begin
          next_ev.cause    = 8'(i);
          next_ev.phases   = elem_phases[i];
          next_ev.on_state = elem_operate[i];
        end
      end
    end
    for (int i = 4; i >= 0; i--) begin
      if (pend_gen[i]) begin
        clr_gen = '0;
        clr_gen[i] = 1'b1;
      end
    end
    if (clr_gen != '0) begin
      clr_vi = '0;
      clr_ci = '0;
      clr_do = '0;
      clr_pu = '0;
      clr_op = '0;
      next_ev.etype = EV_GENERAL;
      next_ev.phases = '0;
      next_ev.on_state = 1'b0;
      for (int i = 0; i < 5; i++)
        if (clr_gen[i])
          next_ev.cause = 8'(i);
    end
    // Trips of a function disabled or not a logged type become general-less and drop.
    ev_fire = (clr_gen | clr_vi | clr_ci | clr_do | clr_pu | clr_op) != '0
              && !(next_ev.etype == EV_GENERAL && clr_gen == '0)
              && !type_filter[next_ev.etype];
  end

  // Circular log write; the oldest entry is overwritten once full.
  always_ff @(posedge core_clk) begin
    if (ev_fire && !clear_log_cmd)
      log_mem[wr_ptr] <= next_ev;
  end

  // The sequence number is 16 bits wide and rolls over after 65535 events.
  always_ff @(posedge core_clk) begin
    if (srst || clear_log_cmd) begin
      wr_ptr    <= '0;
      seq       <= '0;
      log_count <= '0;
    end else if (ev_fire) begin
      wr_ptr <= wr_ptr + 1'b1;
      seq    <= seq + 16'h0001;
      if (log_count != (AW+1)'(DEPTH))
        log_count <= log_count + 1'b1;
    end
  end

  // Age 0 reads the newest entry.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_valid <= 1'b0;
      rd_event <= '0;
    end else begin
      rd_valid <= rd_req && ((AW+1)'(rd_age) < log_count);
      rd_event <= log_mem[wr_ptr - rd_age - 1'b1];
    end
  end

  // Breaker trip total; a counter reset wins over a coincident open.
  always_ff @(posedge core_clk) begin
    if (srst || reset_trip_cmd)
      breaker_trips <= '0;
    else if (breaker_open && !prev_open && !stats_inhibit)
      breaker_trips <= breaker_trips + 32'h1;
  end

  // Cause counters follow the rising edge of the trip relay request.
  always_ff @(posedge core_clk) begin
    if (srst || reset_trip_cmd)
      cause_trips <= '0;
    else if (trip_edge && trip_cause_valid && !stats_inhibit)
      cause_trips[trip_cause_id] <= cause_trips[trip_cause_id] + 16'h0001;
  end

  always_ff @(posedge core_clk) begin
    if (srst)
      trip_reset_date <= '0;
    else if (reset_trip_cmd)
      trip_reset_date <= now.date;
  end

  // Arcing wear, saturating at the top of range.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      arc_total      <= '0;
      arc_reset_date <= '0;
    end else if (reset_arc_cmd) begin
      arc_total      <= '0;
      arc_reset_date <= now.date;
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (arc_valid[p])
          arc_total[p] <= ({1'b0, arc_total[p]} + {1'b0, arc_incr[p]} > {1'b0, ARC_MAX})
                        ? ARC_MAX : arc_total[p] + arc_incr[p];
      end
    end
  end

endmodule

// [breaker_stats_pkg.sv]
package breaker_stats_pkg;

  localparam int LOG_DEPTH       = 512;
  localparam int NUM_CAUSE_CNT   = 16;
  localparam int NUM_ELEM        = 32;
  localparam int NUM_INPUTS      = 20;
  localparam logic [15:0] ARC_MAX = 16'hffff;

  typedef enum logic [3:0] {
    EV_GENERAL, EV_PICKUP, EV_TRIP, EV_ALARM, EV_LATCHED,
    EV_CONTROL, EV_DROPOUT, EV_CONTACT, EV_VIRTUAL
  } ev_type_t;

  typedef enum logic [2:0] {
    FN_DISABLED, FN_TRIP, FN_TRIP_RECLOSE, FN_ALARM, FN_LATCHED, FN_CONTROL
  } elem_func_t;

  typedef enum logic [3:0] {
    GC_BREAKER_OPEN, GC_BREAKER_CLOSED, GC_RESET_TRIP, GC_RESET_ARC, GC_CLEAR_LOG
  } gen_cause_t;

  typedef struct packed {
    logic [31:0] date;
    logic [31:0] time_ms;
  } stamp_t;

  typedef struct packed {
    logic [15:0] mag;
    logic [8:0]  lag;
  } phasor_t;

  // Voltages carry both phase-to-neutral and line-to-line sets.
  typedef struct packed {
    phasor_t [2:0] ia;
    phasor_t       gnd;
    phasor_t       sgnd;
    phasor_t [2:0] v_ln;
    phasor_t [2:0] v_ll;
    logic [15:0]   sys_freq;
    phasor_t       sync_v;
    logic [15:0]   sync_freq;
    logic [15:0]   analog;
  } meas_t;

  typedef struct packed {
    phasor_t [2:0] v;
    logic [15:0]   sys_freq;
    phasor_t       sync_v;
    logic [15:0]   sync_freq;
    logic [15:0]   analog;
    phasor_t [4:0] cur;
  } snap_t;

  typedef struct packed {
    logic [15:0] seq;
    stamp_t      stamp;
    ev_type_t    etype;
    logic [7:0]  cause;
    logic [2:0]  phases;
    logic        on_state;
    logic        delta;
    snap_t       snap;
  } event_t;

  localparam logic [8:0] TYPE_FILTER_RST = 9'h000;

endpackage

// [breaker_stats_event_recorder_checker.sv]
`timescale 1ns/100ps
module breaker_stats_event_recorder_checker
  import breaker_stats_pkg::*;
#(
  parameter int DEPTH = LOG_DEPTH
) (
  // Clock and reset.
  input wire logic                      core_clk,
  input wire logic                      srst,
  // Sources and commands.
  input wire logic                      breaker_open,
  input wire logic                      stats_inhibit,
  input wire logic [2:0]                arc_valid,
  input wire logic [2:0][15:0]          arc_incr,
  input wire logic                      reset_trip_cmd,
  input wire logic                      reset_arc_cmd,
  input wire logic                      clear_log_cmd,
  // Display side.
  input wire logic [$clog2(DEPTH)-1:0]  rd_age,
  input wire logic                      rd_req,
  input wire logic                      rd_valid,
  input wire logic [$clog2(DEPTH):0]    log_count,
  input wire logic [31:0]               breaker_trips,
  input wire logic [2:0][15:0]          arc_total
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_trip_count: assert property ($rose(breaker_open) && !stats_inhibit && !reset_trip_cmd
    |=> breaker_trips == $past(breaker_trips) + 1) else $error("trip count not advanced");
  a_inhibit_freeze: assert property (stats_inhibit && !reset_trip_cmd
    |=> breaker_trips == $past(breaker_trips)) else $error("trip count moved while inhibited");
  a_trip_reset: assert property (reset_trip_cmd |=> breaker_trips == 32'h0)
    else $error("trip count not cleared");
  a_arc_reset: assert property (reset_arc_cmd |=> arc_total == '0)
    else $error("arcing totals not cleared");
  // The 17-bit sum exposes a wrap that a 16-bit adder would hide.
  a_arc_sat: assert property (arc_valid[0] && !reset_arc_cmd |=> arc_total[0] ==
    (($past({1'b0, arc_total[0]}) + $past(arc_incr[0]) > 17'hffff) ? ARC_MAX
    : $past(arc_total[0] + arc_incr[0]))) else $error("arcing total wrong");
  a_read_answer: assert property (rd_req |=> rd_valid == ($past(rd_age) < $past(log_count)))
    else $error("read answer wrong");
  a_full_holds: assert property (log_count == DEPTH && !clear_log_cmd |=> log_count == DEPTH)
    else $error("full log lost entries");
  a_clear_restart: assert property (clear_log_cmd |=> ##[0:3] log_count == 1)
    else $error("clear did not restart log");
  c_full: cover property (log_count == DEPTH);
  c_read: cover property (rd_valid);
  c_inhibited: cover property ($rose(breaker_open) && stats_inhibit);
endmodule
bind breaker_stats_event_recorder breaker_stats_event_recorder_checker #(.DEPTH(DEPTH)) chk (
  .core_clk, .srst, .breaker_open, .stats_inhibit, .arc_valid, .arc_incr, .reset_trip_cmd,
  .reset_arc_cmd, .clear_log_cmd, .rd_age, .rd_req, .rd_valid, .log_count, .breaker_trips,
  .arc_total);

// [breaker_stats_sources.sv]
`timescale 1ns/100ps
module breaker_stats_sources
  import breaker_stats_pkg::*;
(
  // Clock.
  input  wire logic             core_clk,
  // Source levels.
  output logic                  breaker_open = 1'b0,
  output logic                  trip_relay_req = 1'b0,
  output logic [3:0]            trip_cause_id = 4'h0,
  output logic [NUM_ELEM-1:0]   elem_pickup = '0,
  output logic [NUM_ELEM-1:0]   elem_operate = '0,
  output logic [NUM_INPUTS-1:0] contact_in = '0,
  output logic [NUM_INPUTS-1:0] virtual_in = '0
);
  // Each change lands on a falling edge and then stands, since the recorder logs edges.
  task automatic set_src(logic open, logic req, logic [3:0] id);
    @(negedge core_clk);
    trip_cause_id = id;
    breaker_open = open;
    trip_relay_req = req;
  endtask
  task automatic set_elem(int i, logic p, logic o);
    @(negedge core_clk);
    elem_pickup[i] = p;
    elem_operate[i] = o;
  endtask
  task automatic flip(logic virt, int i);
    @(negedge core_clk);
    if (virt) virtual_in[i] = ~virtual_in[i];
    else contact_in[i] = ~contact_in[i];
  endtask
endmodule

// [tb.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  import breaker_stats_pkg::*;
  localparam int D = 8;
  logic                           core_clk = 1'b0, srst = 1'b1, inhibit = 1'b0, vt = 1'b0;
  logic                           rd_req = 1'b0, rd_valid, brk, trip;
  logic [2:0]                     cmds = 3'h0, arc_valid = 3'h0, rd_age = 3'h0;
  logic [3:0]                     cause_id, log_count;
  logic [2:0][15:0]               arc_incr = '0, arc_total;
  logic [NUM_ELEM-1:0]            pick, oper;
  elem_func_t [NUM_ELEM-1:0]      func;
  logic [NUM_INPUTS-1:0]          cin, vin;
  stamp_t                         now = '0;
  meas_t                          meas = '0;
  logic [8:0]                     filt = 9'h0;
  event_t                         rd_event;
  logic [31:0]                    trips, trip_date, arc_date;
  logic [NUM_CAUSE_CNT-1:0][15:0] cause_trips;
  logic [48:0]                    hist[$], sb[$], got, want;
  logic [15:0]                    lfsr = 16'hd08a, seq, ea[3];
  logic [16:0]                    s;
  int                             error_cnt, comparisons, idx;
  breaker_stats_event_recorder #(.DEPTH(D)) DUT (.core_clk, .srst, .breaker_open(brk),
    .trip_relay_req(trip), .trip_cause_id(cause_id), .trip_cause_valid(1'b1),
    .stats_inhibit(inhibit), .arc_valid, .arc_incr, .elem_pickup(pick), .elem_operate(oper),
    .elem_func(func), .elem_phases({NUM_ELEM{3'h5}}), .contact_in(cin), .virtual_in(vin),
    .now, .meas, .vt_wiring_style(vt), .type_filter(filt), .reset_trip_cmd(cmds[0]),
    .reset_arc_cmd(cmds[1]), .clear_log_cmd(cmds[2]), .rd_age, .rd_req, .rd_valid, .rd_event,
    .log_count, .breaker_trips(trips), .cause_trips, .arc_total, .trip_reset_date(trip_date),
    .arc_reset_date(arc_date));
  breaker_stats_sources src (.core_clk, .breaker_open(brk), .trip_relay_req(trip),
    .trip_cause_id(cause_id), .elem_pickup(pick), .elem_operate(oper), .contact_in(cin),
    .virtual_in(vin));
  always #2.5 core_clk = ~core_clk;
  always @(negedge core_clk) now.time_ms <= now.time_ms + 32'h1;
  function automatic logic [15:0] step(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask
  // The expected log is kept newest first, trimmed to the depth like the real one.
  task automatic note(ev_type_t t, int c, logic on);
    seq = seq + 16'h1;
    hist.push_front({t, c[7:0], on,
                     (t inside {[EV_PICKUP:EV_DROPOUT]}) ? 3'h5 : 3'h0, vt,
                     seq, vt ? meas.v_ll[0].mag : meas.v_ln[0].mag});
    if (hist.size() > D) void'(hist.pop_back());
  endtask
  task automatic rd(int a);
    @(negedge core_clk);
    rd_age = a[2:0];
    rd_req = 1'b1;
    if (a < hist.size()) sb.push_back(hist[a]);
    @(negedge core_clk);
    rd_req = 1'b0;
  endtask
  task automatic cmd(int k);
    @(negedge core_clk);
    cmds = 3'h1 << k;
    @(negedge core_clk);
    cmds = 3'h0;
    if (k == 2) begin
      hist.delete();
      seq = 16'h0;
    end
    note(EV_GENERAL, k + 2, 1'b0);
    cyc(4);
  endtask
  task automatic final_report();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(negedge core_clk) begin
    if (rd_valid === 1'b1) begin
      got = {rd_event.etype, rd_event.cause, (rd_event.etype inside {EV_CONTACT, EV_VIRTUAL})
             ? rd_event.on_state : 1'b0, rd_event.phases, rd_event.delta, rd_event.seq,
             rd_event.snap.v[0].mag};
      want = sb.size() ? sb.pop_front() : ~got;
      `CHK(got, want)
    end
  end
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
  initial begin
    for (int f = 0; f < NUM_ELEM; f++)
      func[f] = (f == 2) ? FN_ALARM : (f > 8 && f < 14) ? elem_func_t'(f - 8) : FN_DISABLED;
    now.date = {16'h0, lfsr};
    ea = '{3{16'h0}};
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    cmd(2);
    for (int i = 0; i < 10; i++) begin
      lfsr = step(lfsr);
      meas.v_ln[0].mag = lfsr;
      meas.v_ll[0].mag = ~lfsr;
      idx = int'(lfsr[3:0]) + int'(lfsr[4]);
      src.flip(lfsr[5], idx);
      note(lfsr[5] ? EV_VIRTUAL : EV_CONTACT, idx, lfsr[5] ? vin[idx] : cin[idx]);
      cyc(4);
    end
    `CHK(log_count, 4'h8)
    for (int a = 0; a < D; a++) rd(a);
    filt = 9'h1 << EV_CONTACT;
    src.flip(1'b0, 0);
    cyc(4);
    filt = 9'h0;
    src.flip(1'b1, 0);
    note(EV_VIRTUAL, 0, vin[0]);
    cyc(4);
    rd(0);
    rd(1);
    $display("[TEST] ring and filter done");
    src.set_src(1'b1, 1'b0, 4'h5);
    note(EV_GENERAL, 0, 1'b0);
    cyc(4);
    src.set_src(1'b1, 1'b1, 4'h5);
    cyc(4);
    `CHK(trips, 32'h1)
    `CHK(cause_trips[5], 16'h1)
    inhibit = 1'b1;
    src.set_src(1'b0, 1'b0, 4'h5);
    note(EV_GENERAL, 1, 1'b0);
    cyc(4);
    src.set_src(1'b1, 1'b1, 4'h5);
    note(EV_GENERAL, 0, 1'b0);
    cyc(4);
    `CHK({trips, cause_trips[5]}, {32'h1, 16'h1})
    inhibit = 1'b0;
    cmd(0);
    `CHK({trips, trip_date}, {32'h0, now.date})
    for (int a = 0; a < 4; a++) rd(a);
    $display("[TEST] trip counters done");
    for (int i = 0; i < 3; i++) begin
      lfsr = step(lfsr);
      arc_valid = 3'h7;
      arc_incr = {lfsr | 16'h8000, lfsr >> 2, lfsr >> 4};
      for (int k = 0; k < 3; k++) begin
        s = {1'b0, ea[k]} + arc_incr[k];
        ea[k] = s[16] ? 16'hffff : s[15:0];
      end
      @(negedge core_clk);
    end
    arc_valid = 3'h0;
    cyc(2);
    for (int k = 0; k < 3; k++) `CHK(arc_total[k], ea[k])
    cmd(1);
    `CHK({arc_total, arc_date}, {48'h0, now.date})
    $display("[TEST] arcing done");
    vt = 1'b1;
    for (int i = 0; i < 4; i++) begin
      src.set_elem(2, i < 3, i == 1);
      note(i == 3 ? EV_DROPOUT : i ? EV_ALARM : EV_PICKUP, 2, 1'b0);
      cyc(4);
    end
    for (int f = 1; f < 6; f++) begin
      src.set_elem(8 + f, 1'b0, 1'b1);
      note(f < 3 ? EV_TRIP : f == 3 ? EV_ALARM : f == 4 ? EV_LATCHED : EV_CONTROL, 8 + f, 1'b0);
      cyc(4);
    end
    for (int a = 0; a < D; a++) rd(a);
    $display("[TEST] elements done");
    cmd(2);
    `CHK(log_count, 4'h1)
    rd(0);
    rd(1);
    cyc(3);
    `CHK(sb.size(), 0)
    $display("[TEST] clear done");
    final_report();
  end
endmodule
